// File: hdl/lpe_pkg.sv
// Function
// - present error: 4-bit signed, low register
// - error counts clocks between LMFC and SYSREF
// - adjustment moves error to last, zeroes present
// - below-window flag at high register bit 7
// - above-window flag at high register bit 6
// - armed SYSREF sets sticky trip flag
// - outside-window flag when error exceeds window
package lpe_pkg;
  localparam int unsigned ADDR_W       = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL     = 10'h030;
  localparam logic [9:0]  IDX_ISTAT    = 10'h031;
  localparam logic [9:0]  IDX_IMASK    = 10'h032;
  localparam logic [9:0]  IDX_ERR_LOW  = 10'h03D;
  localparam logic [9:0]  IDX_ERR_HIGH = 10'h03E;
  localparam logic [9:0]  IDX_LAST     = 10'h03F;
  // field positions
  localparam int unsigned BELOW_BIT    = 7;
  localparam int unsigned ABOVE_BIT    = 6;
  localparam int unsigned TRIP_BIT     = 4;
  localparam int unsigned OUTSIDE_BIT  = 5;
  localparam int unsigned EV_TRIP      = 0;
  localparam int unsigned EV_ADJUST    = 1;
  localparam int unsigned EV_OUTSIDE   = 2;
  localparam int unsigned EV_N         = 3;
  // counts and limits
  localparam logic [3:0]  CNT_SAT      = 4'hF;
  localparam logic [3:0]  POS_MAX      = 4'h7;
  localparam logic [3:0]  NEG_MAX      = 4'h8;
  localparam logic [3:0]  ERR_RESET    = 4'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  // control register layout, bits [9:0]
  typedef struct packed {
    logic       adj_en;   // bit 9
    logic       arm;      // bit 8 (write 1 arms, reads armed state)
    logic [3:0] win_hi;   // bits 7:4 signed upper bound
    logic [3:0] win_lo;   // bits 3:0 signed lower bound
  } lpe_ctrl_t;
  localparam lpe_ctrl_t CTRL_RESET = '{adj_en: 1'b0, arm: 1'b0,
                                       win_hi: 4'h1, win_lo: 4'hF};
endpackage

// File: hdl/lpe_phase_err.sv
`timescale 1ns/1ns
module lpe_phase_err (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        lmfc_edge,
  input  wire logic                        sysref_edge,
  output logic                             clk_adjust,
  output logic                             irq,
  input  wire logic [lpe_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [lpe_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);

  // measurement state
  logic [3:0]            cnt_l_ff, nxt_cnt_l;  // clocks since last lmfc
  logic [3:0]            cnt_s_ff, nxt_cnt_s;  // clocks since last sysref
  logic                  pend_ff, nxt_pend;    // sysref waits for lmfc
  logic [3:0]            cur_ff, nxt_cur;     // present_phase_offset
  logic [3:0]            last_ff, nxt_last;   // previous_adjust_offset
  logic                  below_ff, nxt_below;
  logic                  above_ff, nxt_above;
  logic                  outside_ff, nxt_outside;
  logic                  trip_ff, nxt_trip;
  logic                  adj_ff, nxt_adj;
  // register state
  lpe_pkg::lpe_ctrl_t    ctrl_ff, nxt_ctrl;
  logic [lpe_pkg::EV_N-1:0] ist_ff, nxt_ist, msk_ff, nxt_msk;
  logic                  irq_ff, nxt_irq;
  // bus state
  logic [lpe_pkg::ADDR_W-1:0] awa_ff, nxt_awa;
  logic                  awh_ff, nxt_awh;     // address held
  logic                  wh_ff, nxt_wh;       // data held
  logic [31:0]           wd_ff, nxt_wd;
  logic [3:0]            ws_ff, nxt_ws;
  logic                  bv_ff, nxt_bv;
  logic                  rv_ff, nxt_rv;
  logic [1:0]            br_ff, nxt_br;
  logic [1:0]            rr_ff, nxt_rr;
  logic [31:0]           rd_ff, nxt_rd;

  // combinational helpers
  logic                  meas_vld;
  logic [3:0]            meas_val;
  logic [9:0]            widx;
  logic [9:0]            ridx;
  logic                  do_wr;
  logic                  do_rd;
  logic [lpe_pkg::EV_N-1:0] ev;

  // phase measurement, adjustment and status
  always_comb begin
    // counters saturate so a stale edge cannot wrap to a near value
    nxt_cnt_l = (cnt_l_ff == lpe_pkg::CNT_SAT) ? cnt_l_ff : cnt_l_ff + 4'h1;
    nxt_cnt_s = (cnt_s_ff == lpe_pkg::CNT_SAT) ? cnt_s_ff : cnt_s_ff + 4'h1;
    nxt_pend  = pend_ff;
    meas_vld  = 1'b0;
    meas_val  = lpe_pkg::ERR_RESET;
    // an edge restarts its counter at one, the first clock after it
    if (lmfc_edge) begin
      nxt_cnt_l = 4'h1;
    end
    if (sysref_edge) begin
      nxt_cnt_s = 4'h1;
    end
    // distance in clocks between the two edges, signed
    if (lmfc_edge && sysref_edge) begin
      meas_vld = 1'b1;
      nxt_pend = 1'b0;
    end else if (sysref_edge) begin
      // lmfc came first: error is the clocks since it
      if (cnt_l_ff <= lpe_pkg::POS_MAX) begin
        meas_vld = 1'b1;
        meas_val = cnt_l_ff;
      end else begin
        nxt_pend = 1'b1;  // maybe early for the next lmfc edge
      end
    end else if (pend_ff && lmfc_edge) begin
      // sysref came first: error is negative
      meas_vld = 1'b1;
      meas_val = 4'h0 - cnt_s_ff;
      nxt_pend = 1'b0;
    end else if (pend_ff && cnt_s_ff > lpe_pkg::NEG_MAX) begin
      // no lmfc edge close behind: report late by the most
      meas_vld = 1'b1;
      meas_val = lpe_pkg::POS_MAX;
      nxt_pend = 1'b0;
    end
    // adjust only when enabled and the error falls outside the window
    nxt_cur  = cur_ff;
    nxt_last = last_ff;
    nxt_adj  = 1'b0;
    if (meas_vld) begin
      if (ctrl_ff.adj_en &&
          ($signed(meas_val) < $signed(ctrl_ff.win_lo) ||
           $signed(meas_val) > $signed(ctrl_ff.win_hi))) begin
        nxt_last = meas_val;
        nxt_cur  = lpe_pkg::ERR_RESET;
        nxt_adj  = 1'b1;
      end else begin
        nxt_cur  = meas_val;
      end
    end
    // flags follow the stored value, so they drop to 0 after an adjust when the window holds zero
    nxt_below   = $signed(nxt_cur) < $signed(ctrl_ff.win_lo);
    nxt_above   = $signed(nxt_cur) > $signed(ctrl_ff.win_hi);
    nxt_outside = nxt_below | nxt_above;
    nxt_trip    = trip_ff;
    if (do_wr && widx == lpe_pkg::IDX_CTRL && ws_ff[1] && wd_ff[8]) begin
      nxt_trip = 1'b0;  // re-arming starts a fresh trip capture
    end
    // a sysref in the re-arm cycle still trips: set beats clear
    nxt_trip    = nxt_trip | (ctrl_ff.arm & sysref_edge);
  end

  // measurement registers; status fields reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_l_ff   <= lpe_pkg::CNT_SAT;
      cnt_s_ff   <= lpe_pkg::CNT_SAT;
      pend_ff    <= 1'b0;
      cur_ff     <= lpe_pkg::ERR_RESET;
      last_ff    <= lpe_pkg::ERR_RESET;
      below_ff   <= 1'b0;
      above_ff   <= 1'b0;
      outside_ff <= 1'b0;
      trip_ff    <= 1'b0;
      adj_ff     <= 1'b0;
    end else begin
      cnt_l_ff   <= nxt_cnt_l;
      cnt_s_ff   <= nxt_cnt_s;
      pend_ff    <= nxt_pend;
      cur_ff     <= nxt_cur;
      last_ff    <= nxt_last;
      below_ff   <= nxt_below;
      above_ff   <= nxt_above;
      outside_ff <= nxt_outside;
      trip_ff    <= nxt_trip;
      adj_ff     <= nxt_adj;
    end
  end

  // bus handshake: address and data taken in either order
  always_comb begin
    // hold everything unless a handshake moves it
    nxt_awa = awa_ff;
    nxt_awh = awh_ff;
    nxt_wd  = wd_ff;
    nxt_ws  = ws_ff;
    nxt_wh  = wh_ff;
    nxt_bv  = bv_ff;
    nxt_br  = br_ff;
    nxt_rv  = rv_ff;
    nxt_rr  = rr_ff;
    nxt_rd  = rd_ff;
    // write index comes from the held address, read index straight in
    widx    = awa_ff[lpe_pkg::ADDR_W-1:2];
    ridx    = s_axi_araddr[lpe_pkg::ADDR_W-1:2];
    do_wr   = awh_ff && wh_ff && !bv_ff;
    do_rd   = s_axi_arvalid && !rv_ff;
    // capture the address; ready drops while it is held
    if (s_axi_awvalid && !awh_ff) begin
      nxt_awa = s_axi_awaddr;
      nxt_awh = 1'b1;
    end
    // data and strobes latched apart from the address
    if (s_axi_wvalid && !wh_ff) begin
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
      nxt_wh = 1'b1;
    end
    // perform once both halves are held and no response is pending
    if (do_wr) begin
      nxt_awh = 1'b0;
      nxt_wh  = 1'b0;
      nxt_bv  = 1'b1;
      nxt_br  = (widx == lpe_pkg::IDX_CTRL || widx == lpe_pkg::IDX_IMASK) ?
                lpe_pkg::RESP_OKAY : lpe_pkg::RESP_SLVERR;
    end else if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    // read answers in one cycle; unmapped indices return an error
    if (do_rd) begin
      nxt_rv = 1'b1;
      nxt_rr = lpe_pkg::RESP_OKAY;
      nxt_rd = 32'h0000_0000;   // reserved bits stay zero
      unique case (ridx)
        lpe_pkg::IDX_CTRL:     nxt_rd[9:0] = ctrl_ff;
        lpe_pkg::IDX_ISTAT:    nxt_rd[lpe_pkg::EV_N-1:0] = ist_ff;
        lpe_pkg::IDX_IMASK:    nxt_rd[lpe_pkg::EV_N-1:0] = msk_ff;
        lpe_pkg::IDX_ERR_LOW:  nxt_rd[3:0] = cur_ff;
        lpe_pkg::IDX_ERR_HIGH: begin
          nxt_rd[lpe_pkg::BELOW_BIT] = below_ff;
          nxt_rd[lpe_pkg::ABOVE_BIT] = above_ff;
        end
        lpe_pkg::IDX_LAST: begin
          nxt_rd[3:0] = last_ff;
          nxt_rd[lpe_pkg::TRIP_BIT]    = trip_ff;
          nxt_rd[lpe_pkg::OUTSIDE_BIT] = outside_ff;
        end
        default: nxt_rr = lpe_pkg::RESP_SLVERR;
      endcase
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // control, mask and sticky events; a set beats a read-clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_msk  = msk_ff;
    // events: first trip, each adjust, rising outside flag
    ev[lpe_pkg::EV_TRIP]    = ctrl_ff.arm & sysref_edge & ~trip_ff;
    ev[lpe_pkg::EV_ADJUST]  = nxt_adj;
    ev[lpe_pkg::EV_OUTSIDE] = nxt_outside & ~outside_ff;
    // read of status clears it, but a same-cycle event survives
    nxt_ist  = ist_ff;
    if (do_rd && ridx == lpe_pkg::IDX_ISTAT) begin
      nxt_ist = '0;
    end
    nxt_ist = nxt_ist | ev;
    // byte lane 0 holds the window, lane 1 arm and adjust enable
    if (do_wr && widx == lpe_pkg::IDX_CTRL) begin
      if (ws_ff[0]) begin
        nxt_ctrl.win_hi = wd_ff[7:4];
        nxt_ctrl.win_lo = wd_ff[3:0];
      end
      if (ws_ff[1]) begin
        nxt_ctrl.arm    = wd_ff[8];
        nxt_ctrl.adj_en = wd_ff[9];
      end
    end
    // mask takes only the low lane
    if (do_wr && widx == lpe_pkg::IDX_IMASK && ws_ff[0]) begin
      nxt_msk = wd_ff[lpe_pkg::EV_N-1:0];
    end
    // irq from next values so it lines up with the status flop
    nxt_irq = |(nxt_ist & nxt_msk);
  end

  // register and bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= lpe_pkg::CTRL_RESET;
      msk_ff  <= '0;
      ist_ff  <= '0;
      irq_ff  <= 1'b0;
      awa_ff  <= '0;
      awh_ff  <= 1'b0;
      wd_ff   <= 32'h0000_0000;
      ws_ff   <= 4'h0;
      wh_ff   <= 1'b0;
      bv_ff   <= 1'b0;
      br_ff   <= lpe_pkg::RESP_OKAY;
      rv_ff   <= 1'b0;
      rr_ff   <= lpe_pkg::RESP_OKAY;
      rd_ff   <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      msk_ff  <= nxt_msk;
      ist_ff  <= nxt_ist;
      irq_ff  <= nxt_irq;
      awa_ff  <= nxt_awa;
      awh_ff  <= nxt_awh;
      wd_ff   <= nxt_wd;
      ws_ff   <= nxt_ws;
      wh_ff   <= nxt_wh;
      bv_ff   <= nxt_bv;
      br_ff   <= nxt_br;
      rv_ff   <= nxt_rv;
      rr_ff   <= nxt_rr;
      rd_ff   <= nxt_rd;
    end
  end

  // ready is the inverse of a held flop, so it still comes from a register
  assign s_axi_awready = ~awh_ff;
  assign s_axi_wready  = ~wh_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = ~rv_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rresp   = rr_ff;
  assign s_axi_rdata   = rd_ff;
  // status outputs, both registered
  assign irq           = irq_ff;
  assign clk_adjust    = adj_ff;

endmodule

// File: testbench/lpe_sysref_src.sv
`timescale 1ns/1ns
// far side: drives one or two lmfc edges and a sysref edge relative to the first
module lpe_sysref_src (
  input wire logic aclk,
  output logic     lmfc_edge,
  output logic     sysref_edge
);
  initial begin
    lmfc_edge = 1'b0;
    sysref_edge = 1'b0;
  end
  // sysref a cycles after lmfc; optional second lmfc b cycles later
  task automatic fire(input int a, input int b);
    lmfc_edge <= 1'b1;
    sysref_edge <= (a == 0);
    @(posedge aclk);
    lmfc_edge <= 1'b0;
    sysref_edge <= 1'b0;
    if (a > 0) begin
      repeat (a - 1) @(posedge aclk);
      sysref_edge <= 1'b1;
      @(posedge aclk);
      sysref_edge <= 1'b0;
    end
    if (b > 0) begin
      repeat (b - 1) @(posedge aclk);
      lmfc_edge <= 1'b1;
      @(posedge aclk);
      lmfc_edge <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask
endmodule

// File: testbench/lpe_phase_err_assertions.sv
`timescale 1ns/1ns
module lpe_phase_err_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_adjust,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshakes that start each bus step
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  // reset case cannot use the default disable
  property p_rst;
    disable iff (1'b0)
      !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !clk_adjust;
  endproperty
  a_rst: assert property (p_rst) else $error("busy after reset");
  property p_adj; clk_adjust |=> !clk_adjust; endproperty
  a_adj: assert property (p_adj) else $error("adjust too long");
  property p_wr_resp; s_wr |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
  property p_wr_rdy; s_wr |=> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_rdy: assert property (p_wr_rdy) else $error("ready stayed");
  property p_rd_resp; s_rd |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_rd_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("rvalid stuck");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
endmodule
bind lpe_phase_err lpe_phase_err_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .clk_adjust(clk_adjust),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// File: testbench/tb_lmfc_sysref_phase_error_status.sv
`timescale 1ns/1ns
module tb_lmfc_sysref_phase_error_status;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        lmfc, sysref, adj, irq, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, tests_run, adj_n;
  lpe_phase_err u_dut (
    .aclk(aclk), .aresetn(aresetn), .lmfc_edge(lmfc),
    .sysref_edge(sysref), .clk_adjust(adj), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );
  lpe_sysref_src u_src (.aclk(aclk), .lmfc_edge(lmfc), .sysref_edge(sysref));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // counts adjustment pulses
  always @(posedge aclk) begin
    if (adj === 1'b1) adj_n++;
  end
  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic hung(input logic dn);
    if (!dn) begin
      bad_count++;
      $display("unexpected at %0t: bus hang", $time);
      tally_and_finish();
    end
  endtask
  // bready held from the start; each channel dropped at its own take;
  // one idle edge at the end so the next call never re-drives in-step
  task automatic wr(input logic [9:0] i, input logic [31:0] v,
                    input logic [1:0] e);
    logic ta, tw, dn;
    dn = 1'b0;
    awaddr <= {i, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      dn = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (dn) bready <= 1'b0;
    end
    @(posedge aclk);
    hung(dn);
    chk(r === e, "write resp");
  endtask
  task automatic rc(input logic [9:0] i, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, dn;
    dn = 1'b0;
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !dn; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      dn = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (dn) rready <= 1'b0;
    end
    @(posedge aclk);
    hung(dn);
    chk(d === e && r === er, "read value");
  endtask
  // reset values, unmapped and read-only places
  task automatic t_reset;
    rc(lpe_pkg::IDX_CTRL, 32'h0000001F, 2'h0);
    rc(lpe_pkg::IDX_ERR_LOW, 32'h0, 2'h0);
    rc(lpe_pkg::IDX_ERR_HIGH, 32'h0, 2'h0);
    rc(lpe_pkg::IDX_LAST, 32'h0, 2'h0);
    rc(10'h000, 32'h0, lpe_pkg::RESP_SLVERR);
    wr(lpe_pkg::IDX_ERR_LOW, 32'h5, lpe_pkg::RESP_SLVERR);
  endtask
  // positive and zero error, window flags, outside event
  task automatic t_meas;
    u_src.fire(3, 0);
    rc(lpe_pkg::IDX_ERR_LOW, 32'h3, 2'h0);
    rc(lpe_pkg::IDX_ERR_HIGH, 32'h40, 2'h0);
    rc(lpe_pkg::IDX_LAST, 32'h20, 2'h0);
    u_src.fire(0, 0);
    rc(lpe_pkg::IDX_ERR_HIGH, 32'h0, 2'h0);
    rc(lpe_pkg::IDX_ISTAT, 32'h4, 2'h0);
    u_src.fire(10, 2);
    rc(lpe_pkg::IDX_ERR_LOW, 32'hE, 2'h0);
    rc(lpe_pkg::IDX_ERR_HIGH, 32'h80, 2'h0);
    chk(irq === 1'b0, "irq unmasked");
    // sysref with no lmfc behind it: reported late by the most
    u_src.fire(12, 0);
    repeat (6) @(posedge aclk);
    rc(lpe_pkg::IDX_ERR_LOW, 32'h7, 2'h0);
    rc(lpe_pkg::IDX_ERR_HIGH, 32'h40, 2'h0);
  endtask
  // armed trip stays set; masked interrupt raised and cleared
  task automatic t_trip;
    rc(lpe_pkg::IDX_ISTAT, 32'h4, 2'h0);
    wr(lpe_pkg::IDX_IMASK, 32'h1, 2'h0);
    wr(lpe_pkg::IDX_CTRL, 32'h11F, 2'h0);
    u_src.fire(0, 0);
    chk(irq === 1'b1, "irq");
    rc(lpe_pkg::IDX_LAST, 32'h10, 2'h0);
    rc(lpe_pkg::IDX_ISTAT, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk(irq === 1'b0, "irq held");
    u_src.fire(0, 0);
    rc(lpe_pkg::IDX_LAST, 32'h10, 2'h0);
  endtask
  // adjustment moves error to last field, zeroes present
  task automatic t_adj;
    wr(lpe_pkg::IDX_CTRL, 32'h21F, 2'h0);
    u_src.fire(3, 0);
    chk(adj_n == 1, "adjust pulses");
    rc(lpe_pkg::IDX_ERR_LOW, 32'h0, 2'h0);
    rc(lpe_pkg::IDX_LAST, 32'h13, 2'h0);
    rc(lpe_pkg::IDX_ISTAT, 32'h2, 2'h0);
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_meas();
    t_trip();
    t_adj();
    tally_and_finish();
  end
endmodule
